// >>> verilog/scan_dma_pkg.sv
// shared constants for the converter scan and dma address block
package scan_dma_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NUM_INPUTS = 32;
	localparam int INDEX_W = 5;
	localparam int DMA_ADDR_W = 11;
	localparam int RESULT_W = 12;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_SCAN_LOW = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_SCAN_HIGH = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_DMA_CONFIG = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_POINTER = 12'h01C;
	// field positions
	localparam int BIT_BUILD_MODE = 12;
	localparam int BIT_ENABLE = 15;
	localparam int BIT_SOURCE_SEL = 0;
	localparam int SPI_LSB = 2;
	localparam int SPI_MSB = 5;
	localparam int BUFSIZE_LSB = 0;
	localparam int BUFSIZE_MSB = 2;
	localparam int ST_SEQ_DONE = 0;
	localparam int ST_DMA_REQ = 1;
	localparam int ST_NO_INPUT = 2;
	// reset values
	localparam logic [15:0] RST_CONTROL = 16'h0000;
	localparam logic [15:0] RST_SCAN = 16'h0000;
	localparam logic [2:0] RST_STATUS = 3'h0;
	// number of inputs that have a physical pin
	localparam logic [INDEX_W:0] PINNED_INPUTS = 6'h12;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		SCAN_IDLE = 4'b0001,
		SCAN_PICK = 4'b0010,
		SCAN_CONVERT = 4'b0100,
		SCAN_STORE = 4'b1000
	} scan_state_type;
endpackage

// >>> verilog/scan_picker.sv
// finds the next selected input at or after a start index
`timescale 1ns/100ps
module scan_picker (
	// selection
	input wire logic [31:0] scan_bits,
	input wire logic [4:0] start_index,
	// result
	output logic found,
	output logic [4:0] pick_index,
	output logic wrapped
);
	logic [5:0] probe;
	always_comb begin
		found = 1'b0;
		pick_index = 5'h0;
		wrapped = 1'b0;
		probe = 6'h0;
		for (int k = 31; k >= 0; k--) begin
			probe = 6'(start_index) + 6'(k);
			if (scan_bits[probe[4:0]]) begin
				found = 1'b1;
				pick_index = probe[4:0];
				wrapped = probe[5];
			end
		end
	end
endmodule

// >>> verilog/dma_address_gen.sv
// dma buffer address from conversion order or input index
`timescale 1ns/100ps
module dma_address_gen
	import scan_dma_pkg::*;
(
	// configuration
	input wire logic build_mode,
	input wire logic [2:0] buffer_size_log2,
	// position
	input wire logic [INDEX_W-1:0] input_index,
	input wire logic [DMA_ADDR_W-1:0] order_pointer,
	input wire logic [DMA_ADDR_W-1:0] slot_pointer,
	// address
	output logic [DMA_ADDR_W-1:0] dma_address
);
	always_comb begin
		if (build_mode) begin
			dma_address = order_pointer;
		end else begin
			dma_address = DMA_ADDR_W'((DMA_ADDR_W'(input_index) << buffer_size_log2)
				+ slot_pointer);
		end
	end
endmodule

// >>> verilog/adc_scan_dma_interface.sv
// converter scan sequencing, dma request and dma address logic
// Summary of operation
// - either of the two converters can be chosen as the dma request source
// - chosen converter's flag setting after every samples_per_increment plus one stored results issues one dma request
// - samples_per_increment sits at bits 5 to 2 of control two
// - build mode one places results sequentially in conversion order
// - conversion order address equals the non-dma result buffer address
// - build mode zero places results in scatter/gather fashion
// - scatter/gather address comes from input index and buffer size
// - scan converts inputs whose select bit is one, skips zeros
// - upper scan register bit x selects input x, 16 to 31
// - lower scan register bit x selects input x, 0 to 15
// - all upper bits writable; unpinned selected inputs convert low reference
// - all lower bits writable; unpinned selected inputs convert low reference
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module adc_scan_dma_interface
	import scan_dma_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [scan_dma_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [scan_dma_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [scan_dma_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [scan_dma_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter core
	input wire logic conv_trigger,
	output logic conv_start,
	output logic [scan_dma_pkg::INDEX_W-1:0] conv_channel,
	output logic conv_low_reference,
	input wire logic conv_done,
	input wire logic [scan_dma_pkg::RESULT_W-1:0] conv_result,
	// dma channel
	output logic converter1_irq_flag,
	output logic converter2_irq_flag,
	output logic dma_request,
	output logic [scan_dma_pkg::DMA_ADDR_W-1:0] dma_address,
	output logic [scan_dma_pkg::RESULT_W-1:0] dma_data,
	// interrupt
	output logic irq
);
	import scan_dma_pkg::*;

	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
		input logic [3:0] strb);
		merge16 = old_v;
		if (strb[0]) merge16[7:0] = wd[7:0];
		if (strb[1]) merge16[15:8] = wd[15:8];
	endfunction

	logic [15:0] control_one_ff;
	logic [15:0] control_two_ff;
	logic [15:0] scan_select_low_ff;
	logic [15:0] scan_select_high_ff;
	logic [2:0] buffer_size_ff;
	logic [2:0] status_ff;
	logic [2:0] irq_mask_ff;
	logic [DMA_ADDR_W-1:0] order_pointer_ff;
	logic [DMA_ADDR_W-1:0] slot_pointer_ff;
	logic [3:0] sample_count_ff;
	scan_state_type state_ff;
	logic [INDEX_W-1:0] index_ff;
	logic [2:0] trig_sync_ff;
	logic trig_last_ff;
	logic dma_request_ff;
	logic [DMA_ADDR_W-1:0] dma_address_ff;
	logic [RESULT_W-1:0] dma_data_ff;
	logic conv_start_ff;
	logic conv_low_ref_ff;

	// axi state
	logic aw_held_ff;
	logic w_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [DATA_W-1:0] rdata_ff;

	logic wr_fire;
	logic rd_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic status_read;
	logic [31:0] scan_bits;
	logic pick_found;
	logic [INDEX_W-1:0] pick_index;
	logic pick_wrapped;
	logic [DMA_ADDR_W-1:0] gen_address;
	logic [3:0] samples_per_increment;
	logic buffer_build_mode;
	logic trig_rise;
	logic sample_stored;
	logic block_done;
	logic [2:0] status_set;
	logic wr_map_ok;

	assign samples_per_increment = control_two_ff[SPI_MSB:SPI_LSB];
	assign buffer_build_mode = control_one_ff[BIT_BUILD_MODE];
	assign scan_bits = {scan_select_high_ff, scan_select_low_ff};

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
	assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
	assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
	assign wr_fire = (aw_held_ff || (s_axi_awvalid && s_axi_awready))
		&& (w_held_ff || (s_axi_wvalid && s_axi_wready));
	assign wr_map_ok = wr_addr[1:0] == 2'h0 && wr_addr <= OFS_POINTER;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= 4'h0;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_map_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// register writes; every scan bit stays writable regardless of pins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_one_ff <= RST_CONTROL;
			control_two_ff <= RST_CONTROL;
			scan_select_low_ff <= RST_SCAN;
			scan_select_high_ff <= RST_SCAN;
			buffer_size_ff <= 3'h0;
			irq_mask_ff <= 3'h0;
		end else if (wr_fire) begin
			case (wr_addr)
				OFS_CONTROL_ONE: control_one_ff <= merge16(control_one_ff, wr_data, wr_strb);
				OFS_CONTROL_TWO: control_two_ff <= merge16(control_two_ff, wr_data, wr_strb);
				OFS_SCAN_LOW: scan_select_low_ff <= merge16(scan_select_low_ff, wr_data,
					wr_strb);
				OFS_SCAN_HIGH: scan_select_high_ff <= merge16(scan_select_high_ff, wr_data,
					wr_strb);
				OFS_DMA_CONFIG: if (wr_strb[0]) buffer_size_ff <= wr_data[BUFSIZE_MSB:BUFSIZE_LSB];
				OFS_IRQ_MASK: if (wr_strb[0]) irq_mask_ff <= wr_data[2:0];
				default: ;
			endcase
		end
	end

	// read channel
	assign s_axi_arready = !rvalid_ff;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign status_read = rd_fire && s_axi_araddr == OFS_STATUS;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= '0;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			case (s_axi_araddr)
				OFS_CONTROL_ONE: rdata_ff <= {16'h0000, control_one_ff};
				OFS_CONTROL_TWO: rdata_ff <= {16'h0000, control_two_ff};
				OFS_SCAN_LOW: rdata_ff <= {16'h0000, scan_select_low_ff};
				OFS_SCAN_HIGH: rdata_ff <= {16'h0000, scan_select_high_ff};
				OFS_DMA_CONFIG: rdata_ff <= {29'h0, buffer_size_ff};
				OFS_STATUS: rdata_ff <= {29'h0, status_ff};
				OFS_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
				OFS_POINTER: rdata_ff <= {5'h0, slot_pointer_ff, 5'h0, order_pointer_ff};
				default: begin
					rdata_ff <= '0;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	// trigger pin synchroniser; a level counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trig_sync_ff <= 3'h0;
			trig_last_ff <= 1'b0;
		end else begin
			trig_sync_ff <= {trig_sync_ff[1:0], conv_trigger};
			if (trig_sync_ff[1] == trig_sync_ff[2]) trig_last_ff <= trig_sync_ff[2];
		end
	end
	assign trig_rise = trig_sync_ff[1] && trig_sync_ff[2] && !trig_last_ff;

	scan_picker u_picker (
		.scan_bits(scan_bits),
		.start_index(index_ff),
		.found(pick_found),
		.pick_index(pick_index),
		.wrapped(pick_wrapped)
	);

	// scan sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= SCAN_IDLE;
			index_ff <= '0;
			conv_start_ff <= 1'b0;
			conv_low_ref_ff <= 1'b0;
		end else begin
			conv_start_ff <= 1'b0;
			case (state_ff)
				SCAN_IDLE: if (trig_rise && control_one_ff[BIT_ENABLE]) begin
					state_ff <= SCAN_PICK;
				end
				SCAN_PICK: if (pick_found && !pick_wrapped) begin
					index_ff <= pick_index;
					conv_low_ref_ff <= {1'b0, pick_index} >= PINNED_INPUTS;
					conv_start_ff <= 1'b1;
					state_ff <= SCAN_CONVERT;
				end else begin
					index_ff <= '0;
					state_ff <= SCAN_IDLE;
				end
				SCAN_CONVERT: if (conv_done) state_ff <= SCAN_STORE;
				SCAN_STORE: begin
					index_ff <= INDEX_W'(index_ff + 1'b1);
					state_ff <= (index_ff == 5'h1F) ? SCAN_IDLE : SCAN_PICK;
				end
				default: state_ff <= SCAN_IDLE;
			endcase
		end
	end
	assign conv_start = conv_start_ff;
	assign conv_channel = index_ff;
	assign conv_low_reference = conv_low_ref_ff;
	assign sample_stored = state_ff == SCAN_STORE;
	assign block_done = sample_stored && sample_count_ff == samples_per_increment;

	dma_address_gen u_addr (
		.build_mode(buffer_build_mode),
		.buffer_size_log2(buffer_size_ff),
		.input_index(index_ff),
		.order_pointer(order_pointer_ff),
		.slot_pointer(slot_pointer_ff),
		.dma_address(gen_address)
	);

	// sample counting and buffer pointers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_count_ff <= 4'h0;
			order_pointer_ff <= '0;
			slot_pointer_ff <= '0;
		end else if (sample_stored) begin
			order_pointer_ff <= DMA_ADDR_W'(order_pointer_ff + 1'b1);
			if (block_done) begin
				sample_count_ff <= 4'h0;
				if (!buffer_build_mode) begin
					slot_pointer_ff <= DMA_ADDR_W'(slot_pointer_ff + 1'b1);
				end
			end else begin
				sample_count_ff <= sample_count_ff + 4'h1;
			end
		end
	end

	// dma request and payload: one pulse per flag setting
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dma_request_ff <= 1'b0;
			dma_address_ff <= '0;
			dma_data_ff <= '0;
		end else begin
			dma_request_ff <= block_done;
			if (sample_stored) begin
				dma_address_ff <= gen_address;
				dma_data_ff <= conv_result;
			end
		end
	end
	assign dma_request = dma_request_ff;
	assign dma_address = dma_address_ff;
	assign dma_data = dma_data_ff;
	assign converter1_irq_flag = dma_request_ff && !control_two_ff[BIT_SOURCE_SEL];
	assign converter2_irq_flag = dma_request_ff && control_two_ff[BIT_SOURCE_SEL];

	// sticky status, cleared by reading; set wins
	assign status_set = {sample_stored && conv_low_ref_ff, block_done, block_done};
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_ff <= RST_STATUS;
		end else begin
			status_ff <= (status_read ? 3'h0 : status_ff) | status_set;
		end
	end
	assign irq = |(status_ff & irq_mask_ff);

	a_request_follows_block: assert property (@(posedge clk) disable iff (!rst_n)
		block_done |=> dma_request && (converter1_irq_flag ^ converter2_irq_flag))
		else $error("dma request missing after block");
	a_order_address_seq: assert property (@(posedge clk) disable iff (!rst_n)
		sample_stored && buffer_build_mode |=> dma_address == $past(order_pointer_ff))
		else $error("ordered address wrong");
	a_skip_unselected: assert property (@(posedge clk) disable iff (!rst_n)
		conv_start |-> scan_bits[conv_channel])
		else $error("unselected input converted");
	a_low_ref_unpinned: assert property (@(posedge clk) disable iff (!rst_n)
		conv_start |-> conv_low_reference == ({1'b0, conv_channel} >= PINNED_INPUTS))
		else $error("reference choice wrong");
	a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
		sample_stored |-> sample_count_ff <= samples_per_increment)
		else $error("sample count overflow");
	a_read_clears_irq: assert property (@(posedge clk) disable iff (!rst_n)
		status_read && status_set == 3'h0 |=> !irq)
		else $error("status read left irq high");
	a_single_request: assert property (@(posedge clk) disable iff (!rst_n)
		dma_request |=> !dma_request)
		else $error("request longer than a cycle");
	a_scatter_address: assert property (@(posedge clk) disable iff (!rst_n)
		sample_stored && !buffer_build_mode |=> dma_address ==
		DMA_ADDR_W'((DMA_ADDR_W'($past(index_ff)) << buffer_size_ff) + $past(slot_pointer_ff)))
		else $error("scatter address wrong");
endmodule

// >>> bench/conv_model.sv
// converter core model answering each start with a coded result
`timescale 1ns/100ps
module conv_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// converter link
	input wire logic conv_start,
	input wire logic [4:0] conv_channel,
	input wire logic conv_low_reference,
	input wire logic [3:0] delay,
	output logic conv_done,
	output logic [11:0] conv_result
);
	logic busy_ff;
	logic [3:0] cnt_ff;
	logic [4:0] ch_ff;
	logic low_ff;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			cnt_ff <= 4'h0;
			ch_ff <= 5'h00;
			low_ff <= 1'b0;
			conv_done <= 1'b0;
			conv_result <= 12'h000;
		end else begin
			conv_done <= 1'b0;
			if (conv_start) begin
				// result is meaningless while a conversion runs
				conv_result <= ~conv_result;
				busy_ff <= 1'b1;
				cnt_ff <= delay;
				ch_ff <= conv_channel;
				low_ff <= conv_low_reference;
			end else if (busy_ff && cnt_ff == 4'h0) begin
				busy_ff <= 1'b0;
				conv_done <= 1'b1;
				conv_result <= {low_ff ? 4'h1 : 4'h5, 3'h0, ch_ff};
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end
endmodule

// >>> bench/adc_scan_dma_interface_test.sv
// self-checking bench for the scan dma block
`timescale 1ns/100ps
module adc_scan_dma_interface_test;
	import scan_dma_pkg::*;
	logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, conv_trigger, conv_start, conv_low_reference, conv_done;
	logic converter1_irq_flag, converter2_irq_flag, dma_request, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr, conv_result, dma_data, last_data;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, rv, q;
	logic [3:0] s_axi_wstrb, delay, sb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [4:0] conv_channel;
	logic [10:0] dma_address;
	logic [4:0] chq[$];
	logic lrq[$];
	logic [22:0] smq[$];
	int err_count, comparisons, nreq, nf1, nf2, j;
	int seed = 32'h4dbcde9b;
	adc_scan_dma_interface dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_trigger, .conv_start, .conv_channel,
		.conv_low_reference, .conv_done, .conv_result, .converter1_irq_flag,
		.converter2_irq_flag, .dma_request, .dma_address, .dma_data, .irq);
	conv_model partner (.clk, .rst_n, .conv_start, .conv_channel, .conv_low_reference,
		.delay, .conv_done, .conv_result);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rst_n) begin
			if (conv_start) begin
				chq.push_back(conv_channel);
				lrq.push_back(conv_low_reference);
			end
			if (dma_data !== last_data)
				smq.push_back({dma_address, dma_data});
			last_data = dma_data;
			nreq += int'(dma_request);
			nf1 += int'(converter1_irq_flag);
			nf2 += int'(converter2_irq_flag);
		end
	end
	task final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s %h %h", $time, msg, seen, exp);
		end
	endtask
	function automatic logic [31:0] merged(input logic [31:0] old_v, input logic [31:0] nv,
		input logic [3:0] s);
		merged = {16'h0000, s[1] ? nv[15:8] : old_v[15:8], s[0] ? nv[7:0] : old_v[7:0]};
	endfunction
	task hang();
		err_count++;
		final_report();
	endtask
	task wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 100) hang();
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 100) hang();
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task rst();
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chq = {};
		lrq = {};
		smq = {};
		{nreq, nf1, nf2} = 0;
		last_data = 12'h000;
	endtask
	task scan(input logic [31:0] sel, input logic [15:0] c1, input logic [15:0] c2,
		input logic [2:0] sz, input logic msk);
		int i, k, n, e;
		rst();
		wr(OFS_SCAN_LOW, {16'h0000, sel[15:0]}, r);
		wr(OFS_SCAN_HIGH, {16'h0000, sel[31:16]}, r);
		wr(OFS_DMA_CONFIG, {29'h0, sz}, r);
		wr(OFS_IRQ_MASK, {31'h0, msk}, r);
		wr(OFS_CONTROL_TWO, {16'h0000, c2}, r);
		wr(OFS_CONTROL_ONE, {16'h0000, c1}, r);
		delay <= 4'($random(seed));
		conv_trigger <= 1'b1;
		repeat (4) @(posedge clk);
		conv_trigger <= 1'b0;
		n = $countones(sel);
		e = n / (int'(c2[5:2]) + 1);
		for (i = 0; i < 3000 && smq.size() < n; i++) @(posedge clk);
		if (i == 3000) hang();
		repeat (20) @(posedge clk);
		chk(smq.size(), n, "samples");
		k = 0;
		for (i = 0; i < 32; i++) if (sel[i]) begin
			chk(chq[k], i, "channel");
			chk(lrq[k], i >= PINNED_INPUTS, "low ref");
			chk(smq[k][11:0], {i >= PINNED_INPUTS ? 4'h1 : 4'h5, 3'h0, i[4:0]}, "data");
			chk(smq[k][22:12], c1[BIT_BUILD_MODE] ? k
				: (i << sz) + k / (int'(c2[5:2]) + 1), "addr");
			k++;
		end
		chk(nreq, e, "requests");
		chk(nf1, c2[0] ? 0 : e, "flag one");
		chk(nf2, c2[0] ? e : 0, "flag two");
		chk(irq, msk && e > 0, "irq");
		rd(OFS_STATUS, d, r);
		chk(d[1:0], e > 0 ? 2'b11 : 2'b00, "status");
		chk(d[2], |(sel >> PINNED_INPUTS), "low ref status");
		repeat (2) @(posedge clk);
		chk(irq, 1'b0, "irq clear");
		$display("scan test done, select %h", sel);
	endtask
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, conv_trigger, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		{delay, err_count, comparisons} = 0;
		s_axi_wstrb = 4'hf;
		rst();
		rd(OFS_SCAN_LOW, d, r);
		chk(d, 32'h0000_0000, "low reset");
		rd(OFS_SCAN_HIGH, d, r);
		chk(d, 32'h0000_0000, "high reset");
		rd(12'h020, d, r);
		chk(r, RESP_SLVERR, "unmapped read");
		wr(12'h024, 32'hffff_ffff, r);
		chk(r, RESP_SLVERR, "unmapped write");
		for (j = 0; j < 8; j++) begin
			rv = $random(seed);
			sb = (j < 4) ? 4'hf : 4'($random(seed));
			rd(j[0] ? OFS_SCAN_HIGH : OFS_SCAN_LOW, d, r);
			s_axi_wstrb <= sb;
			wr(j[0] ? OFS_SCAN_HIGH : OFS_SCAN_LOW, rv, r);
			chk(r, RESP_OKAY, "write response");
			rd(j[0] ? OFS_SCAN_HIGH : OFS_SCAN_LOW, q, r);
			chk(q, merged(d, rv, sb), "scan rw");
		end
		s_axi_wstrb <= 4'hf;
		$display("register test done");
		scan(32'h8004_0011 | ($random(seed) & 32'h0000_0f00), 16'h8000, 16'h003d, 3'h2, 1'b1);
		scan(32'h0000_0013 | ($random(seed) & 32'h00f0_00f0), 16'h9000, 16'h0004, 3'h0, 1'b1);
		scan(32'h8000_0001 | $random(seed), 16'h9000, 16'h0001, 3'h1, 1'b0);
		final_report();
	end
endmodule
